/* File: hw/cpu_ctl_params.svh */
`ifndef CPU_CTL_PARAMS_SVH
`define CPU_CTL_PARAMS_SVH

`define STACK_LEVELS      7
`define ADDR_W            14
// cycle type codes driven on the top two bits at the second state
`define CTYP_FETCH        2'h0
`define CTYP_READ         2'h2
`define CTYP_PORT         2'h1
`define CTYP_WRITE        2'h3
// state codes shown on the status pins
`define ST_CODE_ADDR_LO   3'h2
`define ST_CODE_INT_ACK   3'h6
`define ST_CODE_ADDR_HI   3'h4
`define ST_CODE_WAIT      3'h0
`define ST_CODE_FETCH     3'h1
`define ST_CODE_STOPPED   3'h3
`define ST_CODE_EXEC1     3'h7
`define ST_CODE_EXEC2     3'h5
// restart entry spacing: field shifted left by this much
`define RESTART_SHIFT     3
// flag select codes
`define FSEL_CARRY        2'h0
`define FSEL_ZERO         2'h1
`define FSEL_SIGN         2'h2
`define FSEL_PARITY       2'h3

`endif

/* File: hw/cpu_ctl_pkg.sv */
package cpu_ctl_pkg;

    typedef enum logic [4:0] {
        ST_ADDR_LO = 5'b00001,
        ST_INT_ACK = 5'b00011,
        ST_ADDR_HI = 5'b00010,
        ST_WAIT    = 5'b00110,
        ST_FETCH   = 5'b00100,
        ST_STOPPED = 5'b01100,
        ST_EXEC1   = 5'b01000,
        ST_EXEC2   = 5'b10000
    } state_t;

    typedef enum logic [1:0] {
        CYC_ONE   = 2'b00,
        CYC_TWO   = 2'b01,
        CYC_THREE = 2'b10
    } cycle_t;

    typedef struct packed {
        logic sign;
        logic zero;
        logic parity;
        logic carry;
    } flags_t;

    typedef struct packed {
        logic call_always;
        logic call_if_flag_clear;
        logic call_if_flag_set;
        logic return_always;
        logic return_if_flag_clear;
        logic return_if_flag_set;
        logic restart;
        logic port_read_instr;
        logic port_write_instr;
        logic halt_instr;
        logic jump_any;
        logic mem_load;
        logic mem_store;
    } decode_t;

endpackage

/* File: hw/addr_stack.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_params.svh"

// seven-level return address stack; push and pop are one-cycle strobes
module addr_stack #(
    parameter int LEVELS = `STACK_LEVELS,
    parameter int AW     = `ADDR_W
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rstn,
    input  wire logic          ce,
    // stack control
    input  wire logic          push,
    input  wire logic          pop,
    input  wire logic [AW-1:0] push_addr,
    output logic      [AW-1:0] top_addr
);
    logic [AW-1:0] entry_q [LEVELS];

    assign top_addr = entry_q[0];

    // deeper than seven calls silently drops the oldest address
    genvar i;
    generate
        for (i = 0; i < LEVELS; i++) begin : g_lvl
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    entry_q[i] <= '0;
                end else if (ce && push) begin
                    if (i == 0) begin
                        entry_q[i] <= push_addr;
                    end else begin
                        entry_q[i] <= entry_q[(i == 0) ? 0 : i-1];
                    end
                end else if (ce && pop) begin
                    if (i == LEVELS-1) begin
                        entry_q[i] <= '0;
                    end else begin
                        entry_q[i] <= entry_q[(i == LEVELS-1) ? i : i+1];
                    end
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

/* File: hw/cpu_stack_io_state_control.sv */
// What this block does
// - call pushes pc, loads target; seven levels
// - conditional call on flag match, else skip
// - byte two low, byte three high, top ignored
// - return pops one level into pc
// - conditional return pops on match, else advance
// - restart calls one of eight page-zero entries
// - port read: two cycles, three-bit device field
// - port cycle drives acc, instruction, captures data
// - port fourth state drives flags on bits 0-3
// - port write: five-bit field, acc then instruction
// - halt stops at once, pc already advanced
// - two clock periods per state, sync marks
// - first state: low address out, pc increments
// - interrupt-ack first state holds pc
// - second state: high address, type, carry
// - wait state until ready rises
// - third state fetches, reads or writes
// - stopped until interrupt request
// - first exec state shows data; skipped when unneeded
// - sequencer is five-bit shift register, steered
// - wait and stop cycle inside the third state
// - early return to first state per cycle
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_params.svh"

module cpu_stack_io_state_control #(
    parameter int AW = `ADDR_W
) (
    // clock, reset, enable
    input  wire logic                  mclk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    // control inputs
    input  wire logic                  ready,
    input  wire logic                  int_req,
    input  wire cpu_ctl_pkg::flags_t   flags,
    input  wire logic [7:0]            acc,
    // multiplexed bus
    input  wire logic [7:0]            bus_in,
    output logic      [7:0]            bus_out,
    output logic                       bus_oe,
    // status
    output logic      [2:0]            state_code,
    output logic                       sync,
    output logic                       acc_load,
    output logic      [7:0]            acc_data,
    output logic      [AW-1:0]         pc,
    output logic      [7:0]            instr
);
    cpu_ctl_pkg::state_t st_q, st_d;
    cpu_ctl_pkg::cycle_t cyc_q, cyc_d;
    logic          phase_q;
    logic          int_pend_q;
    logic          ack_q;
    logic          halted_q;
    logic          carry_q;
    logic          taken_q;
    logic [7:0]    ir_q;
    logic [7:0]    lo_q;
    logic [AW-1:0] pc_q;
    logic [7:0]    bus_q;
    logic          oe_q;
    logic          sync_q;
    logic          load_q;
    logic [7:0]    adata_q;
    logic [2:0]    code_q;
    logic [AW-1:0] top_addr;

    function automatic cpu_ctl_pkg::decode_t decode(input logic [7:0] op);
        cpu_ctl_pkg::decode_t d;
        d = '0;
        d.call_always          = (op[7:6] == 2'b01) && (op[2:0] == 3'b110);
        d.call_if_flag_clear   = (op[7:6] == 2'b01) && !op[5] && (op[2:0] == 3'b010);
        d.call_if_flag_set     = (op[7:6] == 2'b01) && op[5] && (op[2:0] == 3'b010);
        d.jump_any             = (op[7:6] == 2'b01) && ((op[2:0] == 3'b100) || (op[2:0] == 3'b000));
        d.return_always        = (op[7:6] == 2'b00) && (op[2:0] == 3'b111);
        d.return_if_flag_clear = (op[7:6] == 2'b00) && !op[5] && (op[2:0] == 3'b011);
        d.return_if_flag_set   = (op[7:6] == 2'b00) && op[5] && (op[2:0] == 3'b011);
        d.restart              = (op[7:6] == 2'b00) && (op[2:0] == 3'b101);
        d.port_read_instr      = (op[7:6] == 2'b01) && (op[5:4] == 2'b00) && op[0];
        d.port_write_instr     = (op[7:6] == 2'b01) && (op[5:4] != 2'b00) && op[0];
        d.halt_instr           = (op[7:1] == 7'b0000000) || (op == 8'hff);
        d.mem_load             = ((op[7:6] == 2'b11) && (op[2:0] == 3'b111) && (op[5:3] != 3'b111))
                                 || ((op[7:6] == 2'b10) && (op[2:0] == 3'b111))
                                 || ((op[7:6] == 2'b00) && (op[2:0] == 3'b110) && (op[5:3] != 3'b111))
                                 || ((op[7:6] == 2'b00) && (op[2:0] == 3'b100));
        d.mem_store            = ((op[7:6] == 2'b11) && (op[5:3] == 3'b111) && (op[2:0] != 3'b111))
                                 || (op == 8'h3e);
        return d;
    endfunction

    function automatic logic flag_pick(input logic [1:0] sel, input cpu_ctl_pkg::flags_t f);
        case (sel)
            `FSEL_CARRY:  flag_pick = f.carry;
            `FSEL_ZERO:   flag_pick = f.zero;
            `FSEL_SIGN:   flag_pick = f.sign;
            `FSEL_PARITY: flag_pick = f.parity;
            default:      flag_pick = f.carry;
        endcase
    endfunction

    // decode of the instruction just arriving (fetch) and the one held
    wire cpu_ctl_pkg::decode_t dec_new = decode(bus_in);
    wire cpu_ctl_pkg::decode_t dec_ir  = decode(ir_q);
    wire cond_new   = flag_pick(bus_in[4:3], flags) == bus_in[5];
    wire is_fetch   = (cyc_q == cpu_ctl_pkg::CYC_ONE);
    wire step       = ce && phase_q;
    wire in_fetch   = (st_q == cpu_ctl_pkg::ST_FETCH);
    wire fetch_now  = step && in_fetch && is_fetch;
    wire ret_go     = dec_new.return_always
                      || ((dec_new.return_if_flag_clear || dec_new.return_if_flag_set) && cond_new);
    wire ret_fail   = (dec_new.return_if_flag_clear || dec_new.return_if_flag_set) && !cond_new;
    wire push_go    = fetch_now && dec_new.restart;
    wire pop_go     = fetch_now && ret_go;
    // push at the edge that loads the target, so the stack gets the return address
    wire call_push  = step && in_fetch && (cyc_q == cpu_ctl_pkg::CYC_THREE) && taken_q && ir_q != 8'h3e
                      && (dec_ir.call_always || dec_ir.call_if_flag_clear
                          || dec_ir.call_if_flag_set);
    wire [AW-1:0] rst_addr = AW'({bus_in[5:3], 3'b000});
    wire [AW-1:0] jmp_addr = {bus_in[5:0], lo_q};
    wire [8:0]    lo_inc   = {1'b0, pc_q[7:0]} + 9'h001;
    wire          ptype    = dec_ir.port_read_instr || dec_ir.port_write_instr;
    wire          port_new = is_fetch && (dec_new.port_read_instr || dec_new.port_write_instr);
    // a port cycle sends no address, so the pc must not move in it
    wire          pc_hold  = (cyc_q == cpu_ctl_pkg::CYC_TWO) && ptype;
    wire [1:0]    ctype    = !is_fetch && ptype ? `CTYP_PORT :
                             (cyc_q == cpu_ctl_pkg::CYC_TWO) && dec_ir.mem_store
                             || (cyc_q == cpu_ctl_pkg::CYC_THREE) && ir_q == 8'h3e ? `CTYP_WRITE :
                             is_fetch ? `CTYP_FETCH : `CTYP_READ;
    wire          ends_c1  = dec_new.halt_instr ? 1'b0 :
                             ret_fail || ret_go || dec_new.restart
                             || !(dec_new.port_read_instr || dec_new.port_write_instr
                                  || dec_new.mem_load || dec_new.mem_store
                                  || dec_new.call_always || dec_new.call_if_flag_clear
                                  || dec_new.call_if_flag_set || dec_new.jump_any);

    addr_stack #(
        .LEVELS    (`STACK_LEVELS),
        .AW        (AW)
    ) u_stack (
        .mclk      (mclk),
        .rstn      (rstn),
        .ce        (ce),
        .push      (push_go || call_push),
        .pop       (pop_go),
        .push_addr (pc_q),
        .top_addr  (top_addr)
    );

    // sequencer: five-bit shift ring, feedback steered by the instruction
    always_comb begin
        st_d  = st_q;
        cyc_d = cyc_q;
        case (st_q)
            cpu_ctl_pkg::ST_ADDR_LO,
            cpu_ctl_pkg::ST_INT_ACK: st_d = cpu_ctl_pkg::ST_ADDR_HI;
            cpu_ctl_pkg::ST_ADDR_HI: st_d = ready ? cpu_ctl_pkg::ST_FETCH : cpu_ctl_pkg::ST_WAIT;
            cpu_ctl_pkg::ST_WAIT:    st_d = ready ? cpu_ctl_pkg::ST_FETCH : cpu_ctl_pkg::ST_WAIT;
            cpu_ctl_pkg::ST_FETCH: begin
                st_d = cpu_ctl_pkg::ST_EXEC1;
                if (is_fetch && dec_new.halt_instr) begin
                    st_d = cpu_ctl_pkg::ST_STOPPED;
                end else if (is_fetch && ends_c1) begin
                    st_d  = cpu_ctl_pkg::ST_EXEC1;
                end else if (is_fetch) begin
                    st_d  = cpu_ctl_pkg::ST_ADDR_LO;
                    cyc_d = cpu_ctl_pkg::CYC_TWO;
                end else if (cyc_q == cpu_ctl_pkg::CYC_TWO
                             && (dec_ir.port_write_instr || dec_ir.mem_store)) begin
                    st_d  = cpu_ctl_pkg::ST_ADDR_LO;
                    cyc_d = cpu_ctl_pkg::CYC_ONE;
                end else if (cyc_q == cpu_ctl_pkg::CYC_TWO
                             && (dec_ir.call_always || dec_ir.call_if_flag_clear
                                 || dec_ir.call_if_flag_set || dec_ir.jump_any
                                 || ir_q == 8'h3e)) begin
                    st_d  = cpu_ctl_pkg::ST_ADDR_LO;
                    cyc_d = cpu_ctl_pkg::CYC_THREE;
                end else if (cyc_q == cpu_ctl_pkg::CYC_THREE && (ir_q == 8'h3e || !taken_q)) begin
                    st_d  = cpu_ctl_pkg::ST_ADDR_LO;
                    cyc_d = cpu_ctl_pkg::CYC_ONE;
                end
            end
            cpu_ctl_pkg::ST_STOPPED: st_d = int_req ? cpu_ctl_pkg::ST_INT_ACK
                                                    : cpu_ctl_pkg::ST_STOPPED;
            cpu_ctl_pkg::ST_EXEC1:   st_d = cpu_ctl_pkg::ST_EXEC2;
            cpu_ctl_pkg::ST_EXEC2: begin
                st_d  = (int_pend_q && cyc_q != cpu_ctl_pkg::CYC_TWO) ? cpu_ctl_pkg::ST_INT_ACK
                                                                       : cpu_ctl_pkg::ST_ADDR_LO;
                cyc_d = cpu_ctl_pkg::CYC_ONE;
            end
            default:                 st_d = cpu_ctl_pkg::ST_ADDR_LO;
        endcase
        if (st_d == cpu_ctl_pkg::ST_ADDR_LO && cyc_d == cpu_ctl_pkg::CYC_ONE && int_pend_q) begin
            st_d = cpu_ctl_pkg::ST_INT_ACK;
        end
    end

    wire [2:0] code_d = (st_d == cpu_ctl_pkg::ST_ADDR_LO) ? `ST_CODE_ADDR_LO :
                        (st_d == cpu_ctl_pkg::ST_INT_ACK) ? `ST_CODE_INT_ACK :
                        (st_d == cpu_ctl_pkg::ST_ADDR_HI) ? `ST_CODE_ADDR_HI :
                        (st_d == cpu_ctl_pkg::ST_WAIT)    ? `ST_CODE_WAIT    :
                        (st_d == cpu_ctl_pkg::ST_FETCH)   ? `ST_CODE_FETCH   :
                        (st_d == cpu_ctl_pkg::ST_STOPPED) ? `ST_CODE_STOPPED :
                        (st_d == cpu_ctl_pkg::ST_EXEC1)   ? `ST_CODE_EXEC1   : `ST_CODE_EXEC2;

    // every state is two clock periods; phase toggles each edge
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            phase_q <= 1'b0;
            sync_q  <= 1'b0;
        end else if (ce) begin
            phase_q <= !phase_q;
            sync_q  <= !phase_q;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q       <= cpu_ctl_pkg::ST_STOPPED;
            cyc_q      <= cpu_ctl_pkg::CYC_ONE;
            code_q     <= `ST_CODE_STOPPED;
            int_pend_q <= 1'b0;
        end else if (ce) begin
            if (int_req) begin
                int_pend_q <= 1'b1;
            end else if (step && st_q == cpu_ctl_pkg::ST_INT_ACK) begin
                int_pend_q <= 1'b0;
            end
            if (phase_q) begin
                st_q   <= st_d;
                cyc_q  <= cyc_d;
                code_q <= code_d;
            end
        end
    end

    // program counter, instruction and address bytes
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pc_q    <= '0;
            carry_q <= 1'b0;
            ir_q    <= 8'h00;
            lo_q    <= 8'h00;
            taken_q <= 1'b0;
            ack_q   <= 1'b0;
        end else if (step) begin
            case (st_q)
                cpu_ctl_pkg::ST_ADDR_LO: begin
                    pc_q[7:0] <= pc_hold ? pc_q[7:0] : lo_inc[7:0];
                    carry_q   <= lo_inc[8] && !pc_hold;
                    ack_q     <= 1'b0;
                end
                cpu_ctl_pkg::ST_INT_ACK: begin
                    carry_q <= 1'b0;
                    ack_q   <= 1'b1;
                end
                cpu_ctl_pkg::ST_ADDR_HI: begin
                    if (carry_q) begin
                        pc_q[AW-1:8] <= pc_q[AW-1:8] + 1'b1;
                    end
                end
                cpu_ctl_pkg::ST_FETCH: begin
                    if (is_fetch) begin
                        ir_q    <= bus_in;
                        taken_q <= dec_new.call_always || dec_new.jump_any && bus_in[2:0] == 3'b100
                                   || cond_new;
                        if (ret_go) begin
                            pc_q <= top_addr;
                        end else if (dec_new.restart) begin
                            pc_q <= rst_addr;
                        end
                    end else if (cyc_q == cpu_ctl_pkg::CYC_TWO) begin
                        lo_q <= bus_in;
                    end else if (taken_q && ir_q != 8'h3e
                                 && (dec_ir.jump_any || dec_ir.call_always
                                     || dec_ir.call_if_flag_clear || dec_ir.call_if_flag_set)) begin
                        pc_q <= jmp_addr;
                    end
                end
                default: ;
            endcase
        end
    end

    // bus drive and accumulator capture, registered for clean outputs
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_q   <= 8'h00;
            oe_q    <= 1'b0;
            load_q  <= 1'b0;
            adata_q <= 8'h00;
        end else if (ce) begin
            load_q <= 1'b0;
            if (phase_q) begin
                oe_q <= 1'b1;
                case (st_d)
                    cpu_ctl_pkg::ST_ADDR_LO,
                    cpu_ctl_pkg::ST_INT_ACK: bus_q <= (cyc_d == cpu_ctl_pkg::CYC_TWO && port_new) ? acc
                                                      : pc_q[7:0];
                    cpu_ctl_pkg::ST_ADDR_HI: bus_q <= (!is_fetch && ptype) ? ir_q
                                                      : {ctype, pc_q[AW-1:8]};
                    cpu_ctl_pkg::ST_EXEC1:   bus_q <= (!is_fetch && dec_ir.port_read_instr)
                                                      ? {4'h0, flags.carry, flags.parity, flags.zero, flags.sign}
                                                      : acc;
                    default: begin
                        bus_q <= 8'h00;
                        oe_q  <= (st_d == cpu_ctl_pkg::ST_FETCH) && ctype == `CTYP_WRITE;
                    end
                endcase
                if (st_q == cpu_ctl_pkg::ST_FETCH && !is_fetch && dec_ir.port_read_instr) begin
                    load_q  <= 1'b1;
                    adata_q <= bus_in;
                end
            end
        end
    end

    assign bus_out    = bus_q;
    assign bus_oe     = oe_q;
    assign state_code = code_q;
    assign sync       = sync_q;
    assign acc_load   = load_q;
    assign acc_data   = adata_q;
    assign pc         = pc_q;
    assign instr      = ir_q;
endmodule

`default_nettype wire

/* File: bench/cpu_ctl_chk.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_params.svh"

module cpu_ctl_chk #(
    parameter int AW = `ADDR_W
) (
    // clock, reset, enable
    input wire logic                mclk,
    input wire logic                rstn,
    input wire logic                ce,
    // inputs of the block
    input wire logic                ready,
    input wire logic                int_req,
    input wire cpu_ctl_pkg::flags_t flags,
    input wire logic [7:0]          acc,
    input wire logic [7:0]          bus_in,
    // outputs of the block
    input wire logic [7:0]          bus_out,
    input wire logic                bus_oe,
    input wire logic [2:0]          state_code,
    input wire logic                sync,
    input wire logic                acc_load,
    input wire logic [7:0]          acc_data,
    input wire logic [AW-1:0]       pc,
    input wire logic [7:0]          instr
);
    logic port_q;
    // remembers the cycle type so exec states of a port cycle can be told apart
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) port_q <= 1'b0;
        else if (state_code == `ST_CODE_ADDR_HI) port_q <= bus_out[7:6] == `CTYP_PORT;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_sync; ce && $past(rstn) |=> sync != $past(sync); endproperty
    a_sync: assert property (p_sync) else $error("sync did not toggle");
    property p_two; $changed(state_code) |=> $stable(state_code); endproperty
    a_two: assert property (p_two) else $error("state lasted one clock");
    property p_hi; (state_code inside {`ST_CODE_ADDR_LO, `ST_CODE_INT_ACK}) ##1 $changed(state_code)
        |-> state_code == `ST_CODE_ADDR_HI; endproperty
    a_hi: assert property (p_hi) else $error("high address state skipped");
    property p_wait; state_code == `ST_CODE_WAIT && !ready |=> state_code == `ST_CODE_WAIT; endproperty
    a_wait: assert property (p_wait) else $error("left wait without ready");
    property p_inc; state_code == `ST_CODE_ADDR_HI && $past(state_code) == `ST_CODE_ADDR_LO
        && bus_out[7:6] != `CTYP_PORT |-> pc[7:0] == $past(bus_out) + 8'h01; endproperty
    a_inc: assert property (p_inc) else $error("pc not advanced");
    property p_ack; state_code == `ST_CODE_ADDR_HI && $past(state_code) == `ST_CODE_INT_ACK
        |-> pc[7:0] == $past(bus_out); endproperty
    a_ack: assert property (p_ack) else $error("pc moved in ack");
    property p_pacc; $changed(state_code) && state_code == `ST_CODE_ADDR_HI && bus_out[7:6] == `CTYP_PORT
        |-> $past(bus_out) == $past(acc) && bus_out == instr; endproperty
    a_pacc: assert property (p_pacc) else $error("port cycle bus wrong");
    property p_flags; port_q && state_code == `ST_CODE_EXEC1 && instr[5:4] == 2'h0
        |-> bus_out[3:0] == {flags.carry, flags.parity, flags.zero, flags.sign}; endproperty
    a_flags: assert property (p_flags) else $error("flags not on bus");
    property p_load; acc_load |-> acc_data == $past(bus_in) ##1 !acc_load; endproperty
    a_load: assert property (p_load) else $error("port data not captured");
    property p_stop; state_code == `ST_CODE_STOPPED && !int_req && !$past(int_req)
        |=> state_code == `ST_CODE_STOPPED; endproperty
    a_stop: assert property (p_stop) else $error("left stopped state");
    property p_oe; state_code inside {`ST_CODE_ADDR_LO, `ST_CODE_ADDR_HI} |-> bus_oe; endproperty
    a_oe: assert property (p_oe) else $error("address not driven");
    c_wait: cover property (state_code == `ST_CODE_WAIT);
    c_load: cover property (acc_load);
    c_ack: cover property (state_code == `ST_CODE_INT_ACK);
endmodule

bind cpu_stack_io_state_control cpu_ctl_chk #(.AW(AW)) chk_u (.*);
`default_nettype wire

/* File: bench/mem_port_model.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_params.svh"

module mem_port_model (
    // clock
    input  wire logic       mclk,
    // from the block
    input  wire logic [7:0] bus_out,
    input  wire logic [2:0] state_code,
    // bench controls
    input  wire logic [7:0] port_data,
    input  wire logic [7:0] delay,
    // answers
    output logic      [7:0] bus_in,
    output logic            ready
);
    logic [7:0] mem [0:63];
    logic [7:0] lo_q;
    logic [7:0] hi_q;
    logic       ack_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    logic [7:0] last_q = 8'h00;
    wire        drive = state_code == `ST_CODE_FETCH && hi_q[7:6] != `CTYP_WRITE;
    // the acknowledge fetch is answered with a restart to entry zero
    wire  [7:0] word = ack_q ? 8'h05 : hi_q[7:6] == `CTYP_PORT ? port_data : mem[lo_q[5:0]];
    // released bus shows the inverse of the last value so stale data cannot pass
    assign bus_in = drive ? word : ~last_q;
    assign ready = cnt_q >= delay;
    always @(posedge mclk) begin
        if (state_code == `ST_CODE_ADDR_LO || state_code == `ST_CODE_INT_ACK) begin
            lo_q  <= bus_out;
            ack_q <= state_code == `ST_CODE_INT_ACK;
        end
        if (state_code == `ST_CODE_ADDR_HI) hi_q <= bus_out;
        cnt_q <= (state_code == `ST_CODE_ADDR_HI || state_code == `ST_CODE_WAIT) ? cnt_q + 8'h01 : 8'h00;
        if (drive) last_q <= word;
    end
endmodule
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "cpu_ctl_params.svh"

module testbench;
    logic                mclk = 1'b0;
    logic                rstn = 1'b0;
    logic                int_req = 1'b0;
    cpu_ctl_pkg::flags_t flags = 4'h5;
    logic [7:0]          acc = 8'h3c;
    logic [7:0]          delay = 8'h00;
    logic [7:0]          bus_in, bus_out, acc_data, instr, lo, hi;
    logic                bus_oe, ready, sync, acc_load, saw_wait, saw_load;
    logic [2:0]          state_code, lo_code;
    logic [13:0]         pc;
    int                  errors = 0;
    int                  compares = 0;
    always #50 mclk = ~mclk;
    cpu_stack_io_state_control dut_u (.mclk(mclk), .rstn(rstn), .ce(1'b1), .ready(ready),
        .int_req(int_req), .flags(flags), .acc(acc), .bus_in(bus_in), .bus_out(bus_out),
        .bus_oe(bus_oe), .state_code(state_code), .sync(sync), .acc_load(acc_load),
        .acc_data(acc_data), .pc(pc), .instr(instr));
    mem_port_model mem_u (.mclk(mclk), .bus_out(bus_out), .state_code(state_code),
        .port_data(8'ha5), .delay(delay), .bus_in(bus_in), .ready(ready));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results();
        if (errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // runs one machine cycle up to its third state, noting address, wait and load
    task automatic next_cyc();
        saw_wait = 1'b0;
        saw_load = 1'b0;
        for (int i = 0; i < 400 && state_code !== `ST_CODE_ADDR_HI; i++) begin
            @(negedge mclk);
            if (state_code === `ST_CODE_ADDR_LO || state_code === `ST_CODE_INT_ACK) {lo_code, lo} = {state_code, bus_out};
            if (acc_load === 1'b1) saw_load = 1'b1;
            if (state_code === `ST_CODE_INT_ACK) int_req = 1'b0;
        end
        hi = bus_out;
        while (state_code === `ST_CODE_ADDR_HI || state_code === `ST_CODE_WAIT) begin
            @(negedge mclk);
            if (state_code === `ST_CODE_WAIT) saw_wait = 1'b1;
        end
    endtask
    task automatic sc_start();
        repeat (20) @(negedge mclk);
        chk(16'(state_code), 16'(`ST_CODE_STOPPED));
        int_req = 1'b1;
        next_cyc();
        int_req = 1'b0;
        chk(16'(lo_code), 16'(`ST_CODE_INT_ACK));
        chk({hi, lo}, 16'h0000);
    endtask
    task automatic sc_cond_call();
        next_cyc();
        chk({hi, lo}, 16'h0000);
        delay = 8'h05;
        next_cyc();
        delay = 8'h00;
        chk({hi, lo}, 16'h8001);
        chk(16'(saw_wait), 16'h0001);
        next_cyc();
        chk({hi, lo}, 16'h8002);
        next_cyc();
        chk({hi, lo}, 16'h0003);
    endtask
    task automatic sc_call();
        next_cyc();
        next_cyc();
        chk({hi, lo}, 16'h8005);
        next_cyc();
        chk({hi, lo}, 16'h0010);
    endtask
    task automatic sc_port();
        next_cyc();
        chk({hi, lo}, 16'h473c);
        next_cyc();
        chk({hi, lo}, 16'h0011);
        chk({7'h0, saw_load, acc_data}, 16'h01a5);
    endtask
    task automatic sc_ret_rst_halt();
        next_cyc();
        chk({hi, lo}, 16'h0006);
        next_cyc();
        chk({hi, lo}, 16'h0028);
        repeat (40) @(negedge mclk);
        chk(16'(state_code), 16'(`ST_CODE_STOPPED));
        chk(16'(pc), 16'h0029);
    endtask
    initial begin
        for (int i = 0; i < 6; i++) mem_u.mem[i] = 8'(48'h725500_4610c0 >> (40 - 8 * i));
        mem_u.mem[6] = 8'h2d;
        mem_u.mem[16] = 8'h47;
        mem_u.mem[17] = 8'h07;
        mem_u.mem[40] = 8'h00;
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        sc_start();
        sc_cond_call();
        sc_call();
        sc_port();
        sc_ret_rst_halt();
        results();
    end
    // the whole program needs some 170 clocks
    initial begin
        #100000;
        errors++;
        results();
    end
endmodule
`default_nettype wire
